// File: hdl/prin_pkg.sv
// Constants and types shared by the reservation-in responder
package prin_pkg;

    // Command block layout, byte 0 at the top of the 80-bit vector
    localparam int          CDB_W          = 80;
    localparam int          CDB_B_OPC      = 0;
    localparam int          CDB_B_SA       = 1;
    localparam int          CDB_B_RSV_LO   = 2;
    localparam int          CDB_B_RSV_HI   = 6;
    localparam int          CDB_B_ALLOC_HI = 7;
    localparam int          CDB_B_ALLOC_LO = 8;
    localparam logic [7:0]  OPC_PRIN       = 8'h5E;
    localparam logic [2:0]  SA_RSV_BITS    = 3'h0;

    // Service actions of the reservation-in command
    localparam logic [4:0]  SA_READ_KEYS   = 5'h00;
    localparam logic [4:0]  SA_READ_RES    = 5'h01;
    localparam logic [4:0]  SA_REPORT_CAPS = 5'h02;
    localparam logic [4:0]  SA_FULL_STATUS = 5'h03;

    // Service actions of the reservation-out command
    localparam logic [4:0]  PRO_REGISTER   = 5'h00;
    localparam logic [4:0]  PRO_CLEAR      = 5'h03;
    localparam logic [4:0]  PRO_PREEMPT    = 5'h04;
    localparam logic [4:0]  PRO_PREEMPT_AB = 5'h05;
    localparam logic [4:0]  PRO_REG_IGNORE = 5'h06;

    // Sense data for a rejected command, and the empty sense key for good status
    localparam logic [3:0]  SENSE_ILLEGAL  = 4'h5;
    localparam logic [7:0]  ASC_INV_CDB    = 8'h24;
    localparam logic [7:0]  ASCQ_INV_CDB   = 8'h00;
    localparam logic [3:0]  SENSE_NONE     = 4'h0;

    // Registration store
    localparam int          KEY_SLOTS      = 8;
    localparam int          KEY_IDX_W      = 3;
    localparam int          KEY_CNT_W      = 4;
    localparam int          KEY_W          = 64;

    // Parameter data geometry in bytes or 8-byte words, with the generation reset value
    localparam logic [31:0] GEN_RESET      = 32'h0000_0000;
    localparam logic [31:0] RES_DESC_LEN   = 32'h0000_0010;
    localparam logic [3:0]  WORD_BYTES     = 4'h8;
    localparam logic [1:0]  FULL_SUB_LAST  = 2'h2;
    localparam logic [63:0] CAPS_WORD      = 64'h0008_0080_6A00_0000;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_LOAD  = 3'b001,
        ST_BUILD = 3'b010,
        ST_SEND  = 3'b011,
        ST_FIN   = 3'b100,
        ST_STAT  = 3'b101
    } prin_state_t;

endpackage

// File: hdl/prin_key_mem.sv
// Store of registered reservation keys with a registered read port
`timescale 1ns/10ps
module prin_key_mem
    import prin_pkg::*;
(
    // Clock
    input  wire logic                 ref_clk,
    // Write side
    input  wire logic                 wr_en,
    input  wire logic [KEY_IDX_W-1:0] wr_idx,
    input  wire logic [KEY_W-1:0]     wr_key,
    // Read side
    input  wire logic [KEY_IDX_W-1:0] rd_idx,
    output logic      [KEY_W-1:0]     rd_key_q
);

    logic [KEY_W-1:0] mem_q [KEY_SLOTS];

    always_ff @(posedge ref_clk) begin
        if (wr_en) begin
            mem_q[wr_idx] <= wr_key;
        end
    end

    always_ff @(posedge ref_clk) begin
        rd_key_q <= mem_q[rd_idx];
    end

endmodule

// File: hdl/prin_responder.sv
// Reservation-in command decoder and parameter data generator
// Behaviour
// - Opcode 5Eh in byte 0 of a ten-byte block selects this command.
// - Byte 1 low bits hold service action; upper bits, bytes 2-6 zero.
// - Bytes 7-8 carry big-endian allocation length.
// - Data past the allocation length is dropped silently, no error.
// - Actions 00h keys, 01h reservations, 02h capabilities, 03h full status.
// - Reserved action ends in check condition, illegal request, invalid field.
// - Keys data: generation 0-3, length 4-7, eight-byte keys from byte 8.
// - Key list covers every registered initiator through any port.
// - 32-bit generation counts successful register, clear, preempt, ignore.
// - Generation unchanged by reserve, release, in-commands or failures.
// - Generation cleared at power-on and hard reset.
// - Additional length gives true list size regardless of truncation.
// - Reservations data: generation, descriptor byte count, descriptors.
// - One descriptor when a reservation is held, none otherwise.
// - Descriptor: key, zero address, reserved, scope/type, zero extent.
// - Scope in upper nibble of byte 13, type in lower nibble.
`timescale 1ns/10ps
module prin_responder
    import prin_pkg::*;
(
    // Clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 sys_rst,
    input  wire logic                 hard_rst,
    // Command block in
    input  wire logic                 cdb_valid,
    input  wire logic [CDB_W-1:0]     cdb,
    output logic                      cmd_busy_q,
    // Registration state from the reservation-out side
    input  wire logic                 reg_wr_en,
    input  wire logic [KEY_IDX_W-1:0] reg_wr_idx,
    input  wire logic [KEY_W-1:0]     reg_wr_key,
    input  wire logic [KEY_CNT_W-1:0] reg_count,
    input  wire logic                 resv_held,
    input  wire logic [KEY_W-1:0]     resv_key,
    input  wire logic [3:0]           resv_scope,
    input  wire logic [3:0]           resv_type,
    // Reservation-out completion events
    input  wire logic                 pro_done,
    input  wire logic [4:0]           pro_sa,
    input  wire logic                 pro_ok,
    // Parameter data out
    output logic [7:0]                dout_q,
    output logic                      dout_valid_q,
    input  wire logic                 dout_ready,
    // Completion status
    output logic                      sts_valid_q,
    output logic                      sts_check_q,
    output logic [3:0]                sts_sense_key_q,
    output logic [7:0]                sts_asc_q,
    output logic [7:0]                sts_ascq_q,
    // Generation value for observation
    output logic [31:0]               gen_q
);

    prin_state_t          state_q;
    logic [4:0]           sa_q;
    logic [15:0]          alloc_q;
    logic [15:0]          sent_q;
    logic [31:0]          addlen_q;
    logic [5:0]           widx_q;
    logic [5:0]           nwords_q;
    logic [KEY_IDX_W-1:0] kidx_q;
    logic [1:0]           sub_q;
    logic [3:0]           bcnt_q;
    logic [63:0]          word_q;
    logic [63:0]          word_d;
    logic [63:0]          khold_q;
    logic                 held_q;
    logic                 err_q;
    logic [KEY_W-1:0]     mem_rd;

    // Command block fields
    logic [7:0]           c_opc;
    logic [7:0]           c_sa;
    logic [39:0]          c_rsv;
    logic [15:0]          c_alloc;
    logic                 accept;
    logic                 bad_field;
    logic [KEY_CNT_W-1:0] n_keys;
    logic [31:0]          list_len;
    logic [5:0]           n_words;
    logic                 slot;
    logic                 emit;
    logic                 rholder;
    logic                 gen_bump;

    assign c_opc   = cdb[CDB_W-1-8*CDB_B_OPC -: 8];
    assign c_sa    = cdb[CDB_W-1-8*CDB_B_SA -: 8];
    assign c_rsv   = cdb[CDB_W-1-8*CDB_B_RSV_LO -: 40];
    assign c_alloc = {cdb[CDB_W-1-8*CDB_B_ALLOC_HI -: 8],
                      cdb[CDB_W-1-8*CDB_B_ALLOC_LO -: 8]};
    assign accept  = cdb_valid && state_q == ST_IDLE
                     && c_opc == OPC_PRIN;
    assign n_keys  = reg_count;

    // Reserved action codes or nonzero reserved fields are rejected
    assign bad_field = (c_sa[7:5] != SA_RSV_BITS) || (c_rsv != 40'h0)
                       || (c_sa[4:0] > SA_FULL_STATUS);

    // Length of the list after the header and the words to walk
    always_comb begin
        list_len = 32'h0;
        n_words  = 6'h1;
        case (c_sa[4:0])
            SA_READ_KEYS: begin
                list_len = {25'h0, n_keys, 3'h0};
                n_words  = 6'(n_keys) + 6'h1;
            end
            SA_READ_RES: begin
                list_len = resv_held ? RES_DESC_LEN : 32'h0;
                n_words  = resv_held ? 6'h3 : 6'h1;
            end
            SA_REPORT_CAPS: begin
                list_len = 32'h0;
                n_words  = 6'h1;
            end
            SA_FULL_STATUS: begin
                list_len = {24'h0, n_keys, 4'h0}
                           + {25'h0, n_keys, 3'h0};
                n_words  = 6'h1 + 6'(n_keys) + 6'(n_keys) + 6'(n_keys);
            end
            default: begin
                list_len = 32'h0;
                n_words  = 6'h1;
            end
        endcase
    end

    // Holder flag for the registrant being described
    assign rholder = held_q && (khold_q == resv_key);

    // Content of the next eight bytes
    always_comb begin
        word_d = 64'h0;
        case (sa_q)
            SA_READ_KEYS: begin
                word_d = (widx_q == 6'h0) ? {gen_q, addlen_q} : mem_rd;
            end
            SA_READ_RES: begin
                if (widx_q == 6'h0) begin
                    word_d = {gen_q, addlen_q};
                end else if (widx_q == 6'h1) begin
                    word_d = resv_key;
                end else begin
                    word_d = {32'h0, 8'h0, resv_scope, resv_type,
                              16'h0};
                end
            end
            SA_REPORT_CAPS: begin
                word_d = CAPS_WORD;
            end
            SA_FULL_STATUS: begin
                if (widx_q == 6'h0) begin
                    word_d = {gen_q, addlen_q};
                end else if (sub_q == 2'h0) begin
                    word_d = mem_rd;
                end else if (sub_q == 2'h1) begin
                    word_d = {32'h0, 7'h0, rholder, resv_scope, resv_type,
                              16'h0};
                end else begin
                    word_d = 64'h0;
                end
            end
            default: begin
                word_d = 64'h0;
            end
        endcase
    end

    // Every registrant is held in one store, whatever port it came by
    prin_key_mem u_key_mem (
        .ref_clk  (ref_clk),
        .wr_en    (reg_wr_en),
        .wr_idx   (reg_wr_idx),
        .wr_key   (reg_wr_key),
        .rd_idx   (kidx_q),
        .rd_key_q (mem_rd)
    );

    // Generation counter
    assign gen_bump = pro_done && pro_ok
                      && (pro_sa == PRO_REGISTER || pro_sa == PRO_CLEAR
                          || pro_sa == PRO_PREEMPT
                          || pro_sa == PRO_PREEMPT_AB
                          || pro_sa == PRO_REG_IGNORE);

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            gen_q <= GEN_RESET;
        end else if (hard_rst) begin
            gen_q <= GEN_RESET;
        end else if (gen_bump) begin
            gen_q <= gen_q + 32'h1;
        end
    end

    // Output byte handshake
    assign slot = !dout_valid_q || dout_ready;
    assign emit = state_q == ST_SEND && slot && bcnt_q != WORD_BYTES
                  && sent_q != alloc_q;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            dout_valid_q <= 1'b0;
            dout_q       <= 8'h00;
        end else if (emit) begin
            dout_valid_q <= 1'b1;
            dout_q       <= word_q[63:56];
        end else if (dout_ready) begin
            dout_valid_q <= 1'b0;
        end
    end

    // Command sequencer
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q  <= ST_IDLE;
            sa_q     <= SA_READ_KEYS;
            alloc_q  <= 16'h0000;
            sent_q   <= 16'h0000;
            addlen_q <= 32'h0000_0000;
            widx_q   <= 6'h00;
            nwords_q <= 6'h01;
            kidx_q   <= '0;
            sub_q    <= 2'h0;
            bcnt_q   <= 4'h0;
            word_q   <= 64'h0;
            khold_q  <= 64'h0;
            held_q   <= 1'b0;
            err_q    <= 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (accept) begin
                        sa_q     <= c_sa[4:0];
                        alloc_q  <= c_alloc;
                        addlen_q <= list_len;
                        nwords_q <= n_words;
                        held_q   <= resv_held;
                        err_q    <= bad_field;
                        sent_q   <= 16'h0000;
                        widx_q   <= 6'h00;
                        kidx_q   <= '0;
                        sub_q    <= 2'h0;
                        state_q  <= bad_field ? ST_STAT : ST_LOAD;
                    end
                end
                ST_LOAD: begin
                    state_q <= ST_BUILD;
                end
                ST_BUILD: begin
                    word_q  <= word_d;
                    bcnt_q  <= 4'h0;
                    if (sub_q == 2'h0) begin
                        khold_q <= mem_rd;
                    end
                    state_q <= ST_SEND;
                end
                ST_SEND: begin
                    if (slot) begin
                        if (sent_q == alloc_q) begin
                            state_q <= ST_FIN;
                        end else if (bcnt_q == WORD_BYTES) begin
                            if (widx_q + 6'h1 == nwords_q) begin
                                state_q <= ST_FIN;
                            end else begin
                                widx_q  <= widx_q + 6'h1;
                                state_q <= ST_LOAD;
                                if (widx_q != 6'h0) begin
                                    if (sa_q != SA_FULL_STATUS
                                        || sub_q == FULL_SUB_LAST) begin
                                        sub_q  <= 2'h0;
                                        kidx_q <= kidx_q + 1'b1;
                                    end else begin
                                        sub_q <= sub_q + 2'h1;
                                    end
                                end
                            end
                        end else begin
                            word_q <= {word_q[55:0], 8'h00};
                            bcnt_q <= bcnt_q + 4'h1;
                            sent_q <= sent_q + 16'h0001;
                        end
                    end
                end
                ST_FIN: begin
                    if (!dout_valid_q) begin
                        state_q <= ST_STAT;
                    end
                end
                ST_STAT: begin
                    state_q <= ST_IDLE;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Busy flag
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cmd_busy_q <= 1'b0;
        end else if (accept) begin
            cmd_busy_q <= 1'b1;
        end else if (state_q == ST_STAT) begin
            cmd_busy_q <= 1'b0;
        end
    end

    // Completion status; truncation never raises a check
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sts_valid_q     <= 1'b0;
            sts_check_q     <= 1'b0;
            sts_sense_key_q <= SENSE_NONE;
            sts_asc_q       <= 8'h00;
            sts_ascq_q      <= 8'h00;
        end else if (state_q == ST_STAT) begin
            sts_valid_q     <= 1'b1;
            sts_check_q     <= err_q;
            sts_sense_key_q <= err_q ? SENSE_ILLEGAL : SENSE_NONE;
            sts_asc_q       <= err_q ? ASC_INV_CDB : 8'h00;
            sts_ascq_q      <= err_q ? ASCQ_INV_CDB : 8'h00;
        end else begin
            sts_valid_q     <= 1'b0;
        end
    end

endmodule

// File: sim/prin_responder_props.sv
// Concurrent checks on the reservation-in responder ports
`timescale 1ns/10ps
module prin_responder_props
    import prin_pkg::*;
(
    // Clock and reset
    input wire logic             ref_clk,
    input wire logic             sys_rst,
    input wire logic             hard_rst,
    // Command
    input wire logic             cdb_valid,
    input wire logic [CDB_W-1:0] cdb,
    input wire logic             cmd_busy_q,
    // Reservation-out events
    input wire logic             pro_done,
    input wire logic [4:0]       pro_sa,
    input wire logic             pro_ok,
    // Data and status
    input wire logic [7:0]       dout_q,
    input wire logic             dout_valid_q,
    input wire logic             dout_ready,
    input wire logic             sts_valid_q,
    input wire logic             sts_check_q,
    input wire logic [3:0]       sts_sense_key_q,
    input wire logic [7:0]       sts_asc_q,
    input wire logic [7:0]       sts_ascq_q,
    input wire logic [31:0]      gen_q
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    wire idle_in = cdb_valid && !cmd_busy_q;
    wire take    = idle_in && cdb[79:72] == OPC_PRIN;
    wire bad     = cdb[71:69] != 3'h0 || cdb[68:64] > 5'h03
                   || cdb[63:24] != 40'h0;
    wire bump    = pro_done && pro_ok
                   && pro_sa inside {5'h00, 5'h03, 5'h04, 5'h05, 5'h06};

    sequence s_take_bad;
        take && bad;
    endsequence
    sequence s_take_data;
        take && !bad && cdb[23:8] != 16'h0000;
    endsequence
    sequence s_check_sts;
        sts_valid_q && sts_check_q;
    endsequence

    a_take_sets_busy: assert property (take |=> cmd_busy_q)
        else $error("accepted command did not raise busy");
    a_other_opc_ignored: assert property (
        idle_in && cdb[79:72] != OPC_PRIN |=> !cmd_busy_q)
        else $error("foreign opcode was accepted");
    a_bad_field_check: assert property (
        s_take_bad |-> ##[2:3] s_check_sts)
        else $error("bad field did not end in check status");
    a_bad_no_data: assert property (s_take_bad |=> !dout_valid_q [*4])
        else $error("bad field produced data");
    a_data_starts: assert property (s_take_data |-> ##[4:5] dout_valid_q)
        else $error("data did not start on time");
    a_check_sense: assert property (s_check_sts |->
        sts_sense_key_q == SENSE_ILLEGAL && sts_asc_q == ASC_INV_CDB
        && sts_ascq_q == ASCQ_INV_CDB)
        else $error("wrong sense on check");
    a_good_sense_zero: assert property (sts_valid_q && !sts_check_q |->
        sts_sense_key_q == SENSE_NONE && sts_asc_q == 8'h00
        && sts_ascq_q == 8'h00)
        else $error("good status carries sense");
    a_status_one_cycle: assert property (sts_valid_q |=> !sts_valid_q)
        else $error("status longer than one cycle");
    a_byte_held: assert property (dout_valid_q && !dout_ready
        |=> dout_valid_q && $stable(dout_q))
        else $error("byte dropped while stalled");
    a_gen_step: assert property (bump && !hard_rst
        |=> gen_q == $past(gen_q) + 32'h1)
        else $error("generation did not step");
    a_gen_steady: assert property (
        !bump && !hard_rst |=> $stable(gen_q))
        else $error("generation changed without cause");
    a_gen_hard_clr: assert property (hard_rst |=> gen_q == GEN_RESET)
        else $error("hard reset did not clear generation");
endmodule

bind prin_responder prin_responder_props prin_responder_props_i (
    .ref_clk, .sys_rst, .hard_rst, .cdb_valid, .cdb, .cmd_busy_q,
    .pro_done, .pro_sa, .pro_ok, .dout_q, .dout_valid_q, .dout_ready,
    .sts_valid_q, .sts_check_q, .sts_sense_key_q, .sts_asc_q,
    .sts_ascq_q, .gen_q
);

// File: sim/prin_initiator.sv
// Initiator-side sink that collects returned parameter bytes
`timescale 1ns/10ps
module prin_initiator (
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       sys_rst,
    // Data from the responder
    input  wire logic       slow,
    input  wire logic [7:0] dout_q,
    input  wire logic       dout_valid_q,
    output logic            dout_ready
);
    logic [7:0] rx [0:1023];
    int         rx_cnt;

    // A slow sink accepts on every other cycle only
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            dout_ready <= 1'b0;
        end else begin
            dout_ready <= slow ? !dout_ready : 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_cnt <= 0;
        end else if (dout_valid_q && dout_ready) begin
            rx[rx_cnt[9:0]] <= dout_q;
            rx_cnt          <= rx_cnt + 1;
        end
    end
endmodule

// File: sim/prin_responder_tb.sv
// Self-checking bench for the reservation-in responder
`timescale 1ns/10ps
module prin_responder_tb import prin_pkg::*;;
    typedef struct packed {
        logic [4:0]  sa;
        logic [15:0] alloc;
        logic        slow;
        logic        check;
    } prin_row_t;

    logic ref_clk, sys_rst, hard_rst, cdb_valid, cmd_busy_q, reg_wr_en;
    logic [CDB_W-1:0]     cdb;
    logic [KEY_IDX_W-1:0] reg_wr_idx;
    logic [KEY_W-1:0]     reg_wr_key, resv_key;
    logic [KEY_CNT_W-1:0] reg_count;
    logic resv_held, pro_done, pro_ok, dout_valid_q, dout_ready, slow;
    logic sts_valid_q, sts_check_q;
    logic [3:0]  resv_scope, resv_type, sts_sense_key_q;
    logic [4:0]  pro_sa;
    logic [7:0]  dout_q, sts_asc_q, sts_ascq_q;
    logic [31:0] gen_q, exp_gen;
    logic [7:0]  exq [$];
    int          miscompares, num_checks;

    prin_row_t rows [11] = '{
        '{5'h00, 16'h0064, 1'b0, 1'b0}, '{5'h00, 16'h000A, 1'b1, 1'b0},
        '{5'h00, 16'h0020, 1'b0, 1'b0}, '{5'h01, 16'h0064, 1'b1, 1'b0},
        '{5'h01, 16'h0010, 1'b0, 1'b0}, '{5'h02, 16'h0008, 1'b0, 1'b0},
        '{5'h03, 16'h00C8, 1'b0, 1'b0}, '{5'h03, 16'h0007, 1'b1, 1'b0},
        '{5'h04, 16'h0064, 1'b0, 1'b1}, '{5'h1F, 16'h0064, 1'b0, 1'b1},
        '{5'h00, 16'h0000, 1'b0, 1'b0}};

    prin_responder prin_responder_i (.ref_clk, .sys_rst, .hard_rst,
        .cdb_valid, .cdb, .cmd_busy_q, .reg_wr_en, .reg_wr_idx,
        .reg_wr_key, .reg_count, .resv_held, .resv_key, .resv_scope,
        .resv_type, .pro_done, .pro_sa, .pro_ok, .dout_q, .dout_valid_q,
        .dout_ready, .sts_valid_q, .sts_check_q, .sts_sense_key_q,
        .sts_asc_q, .sts_ascq_q, .gen_q);
    prin_initiator prin_initiator_i (.ref_clk, .sys_rst, .slow, .dout_q,
        .dout_valid_q, .dout_ready);

    always #5 ref_clk = ~ref_clk;

    function automatic logic [63:0] key_of(int i);
        return {8'h10 + 8'(i), 48'h2132_4354_6576, 8'hA0};
    endfunction

    function automatic void push(logic [63:0] v, int n);
        for (int i = n - 1; i >= 0; i--) exq.push_back(v[i*8+:8]);
    endfunction

    // Expected parameter data for the current registration state
    function automatic void build(logic [4:0] sa);
        exq.delete();
        if (sa == SA_REPORT_CAPS) begin
            push(CAPS_WORD, 8);
            return;
        end
        push(64'(exp_gen), 4);
        if (sa == SA_READ_RES) begin
            push(resv_held ? 64'h10 : 64'h0, 4);
            if (resv_held) push(resv_key, 8);
            if (resv_held) push({resv_scope, resv_type}, 6);
            if (resv_held) push(64'h0, 2);
        end else begin
            push(sa == SA_FULL_STATUS ? 64'h48 : 64'h18, 4);
            for (int i = 0; i < 3; i++) begin
                push(key_of(i), 8);
                if (sa == SA_FULL_STATUS) begin
                    push({7'h0, resv_held && key_of(i) == resv_key,
                          resv_scope, resv_type}, 6);
                    push(64'h0, 10);
                end
            end
        end
    endfunction

    task chk(logic [31:0] seen, logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic run(logic [7:0] op, logic [4:0] sa, logic [7:0] b3,
                       logic [15:0] alloc, logic bad);
        int base;
        int n;
        base = prin_initiator_i.rx_cnt;
        build(sa);
        cdb       = {op, 3'h0, sa, 8'h00, b3, 24'h0, alloc, 8'h00};
        cdb_valid = 1'b1;
        @(posedge ref_clk);
        #1 cdb_valid = 1'b0;
        n = 0;
        while (sts_valid_q !== 1'b1 && n < 2000 && op == OPC_PRIN) begin
            @(posedge ref_clk);
            #1 n++;
        end
        if (op != OPC_PRIN) begin
            repeat (8) @(posedge ref_clk);
            #1 chk(cmd_busy_q, 0);
            return;
        end
        chk(sts_valid_q, 1);
        chk(sts_check_q, bad);
        chk({sts_sense_key_q, sts_asc_q, sts_ascq_q}, bad ?
            {SENSE_ILLEGAL, ASC_INV_CDB, ASCQ_INV_CDB} : 20'h0);
        n = bad ? 0 : (alloc < exq.size() ? alloc : exq.size());
        chk(prin_initiator_i.rx_cnt - base, n);
        for (int i = 0; i < n; i++)
            chk(prin_initiator_i.rx[base+i], exq[i]);
        @(posedge ref_clk);
        #1;
    endtask

    task automatic events;
        pro_done = 1'b1;
        for (int s = 0; s < 8; s++) begin
            pro_sa = 5'(s);
            pro_ok = 1'b1;
            if (s inside {0, 3, 4, 5, 6}) exp_gen++;
            @(posedge ref_clk);
            #1;
        end
        pro_sa = 5'h00;
        pro_ok = 1'b0;
        @(posedge ref_clk);
        #1 pro_done = 1'b0;
        chk(gen_q, exp_gen);
    endtask

    task summarize;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        #500000 miscompares++;
        summarize();
    end

    initial begin
        {ref_clk, hard_rst, cdb_valid, reg_wr_en, pro_done, pro_ok} = 6'h0;
        {cdb, reg_wr_idx, reg_wr_key, pro_sa, slow, exp_gen} = '0;
        sys_rst    = 1'b1;
        reg_count  = 4'h3;
        resv_held  = 1'b1;
        resv_key   = key_of(1);
        resv_scope = 4'h0;
        resv_type  = 4'h3;
        repeat (12) @(posedge ref_clk);
        chk(gen_q, 0);
        #1 sys_rst = 1'b0;
        reg_wr_en = 1'b1;
        for (int i = 0; i < 3; i++) begin
            reg_wr_idx = 3'(i);
            reg_wr_key = key_of(i);
            @(posedge ref_clk);
            #1;
        end
        reg_wr_en = 1'b0;
        events();
        hard_rst = 1'b1;
        @(posedge ref_clk);
        #1 hard_rst = 1'b0;
        exp_gen = 32'h0;
        chk(gen_q, 0);
        events();
        // Row 2 reissues row 1 with room for all data
        foreach (rows[i]) begin
            slow = rows[i].slow;
            run(OPC_PRIN, rows[i].sa, 8'h00, rows[i].alloc,
                rows[i].check);
        end
        slow = 1'b0;
        run(OPC_PRIN, SA_READ_KEYS, 8'h01, 16'h0064, 1'b1);
        run(8'h5F, SA_READ_KEYS, 8'h00, 16'h0064, 1'b0);
        resv_held = 1'b0;
        run(OPC_PRIN, SA_READ_RES, 8'h00, 16'h0064, 1'b0);
        run(OPC_PRIN, SA_FULL_STATUS, 8'h00, 16'h0064, 1'b0);
        chk(gen_q, exp_gen);
        sys_rst = 1'b1;
        @(posedge ref_clk);
        #1 chk(gen_q, 0);
        summarize();
    end
endmodule
